// [ldc_counters.sv]
// Link diagnostic counter bank with classic Wishbone register access
`timescale 1ns/100ps
// Overview of operation
// - Every counter is a 32-bit unsigned value readable over the register bus.
// - All-ones is never a valid count; it only marks error or overflow.
// - Event counting waits for a successful exchange since the last clear, when enabled.
// - Software reads each counter and clears the whole bank with one control write.
// - Elapsed counter advances every 10 ms since the bank was last zeroed.
// - Frames sent ok counts each acknowledge status received.
// - Frames received ok counts each acknowledge status returned.
// - Exceptions count early bus free, own bus reset during a transmission, or selection timeout.
// - Naks received counts frames answered with a negative status.
// - Illegal phase counts transmitted frames followed by an illegal target phase.
// - Resets driven counts own bus resets; timeout resets also count as exceptions.
// - Resets seen counts detected bus resets not driven by this node.
// - Command check errors count descriptor errors, reserved bits included.
// - Redundancy errors count frames received with checksum or parity errors.
// - Bytes sent total adds the length of every transmitted frame.
// - Bytes received total adds the length of every received frame.
// - Duplicate drops count duplicate packets discarded by the port layer.
// - Datagram drops count datagrams lost for want of a buffer.
// - Response window shows frames sent, naks, exceptions and datagram drops.
// - All other response window words read as zero.
// - One counter set; all but elapsed time and bus resets count one chosen peer node or all nodes.
// - Status byte is 61h for success or 1Eh for failure.
module ldc_counters #(
    parameter int TICK_CYCLES = ldc_pkg::TICK_CYCLES
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // Wishbone slave
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [7:0]               wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    // Datalink and port layer events
    input  wire logic [ldc_pkg::NODE_W-1:0] peer_node_i,
    input  wire logic                     tx_status_vld_i,
    input  wire logic [7:0]               tx_status_byte_i,
    input  wire logic                     rx_status_vld_i,
    input  wire logic [7:0]               rx_status_byte_i,
    input  wire logic                     early_bus_free_i,
    input  wire logic                     sel_timeout_i,
    input  wire logic                     reset_driven_i,
    input  wire logic                     reset_in_tx_i,
    input  wire logic                     own_reset_active_i,
    input  wire logic                     reset_seen_i,
    input  wire logic                     illegal_phase_i,
    input  wire logic                     cmd_err_i,
    input  wire logic                     data_err_i,
    input  wire logic                     tx_len_vld_i,
    input  wire logic [ldc_pkg::LEN_W-1:0] tx_len_i,
    input  wire logic                     rx_len_vld_i,
    input  wire logic [ldc_pkg::LEN_W-1:0] rx_len_i,
    input  wire logic                     dup_drop_i,
    input  wire logic                     dg_drop_i,
    output logic                          comm_ok_o
);

    logic [31:0] cnt_ff [ldc_pkg::NUM_CNT];
    logic [31:0] amt    [ldc_pkg::NUM_CNT];
    logic [31:0] ctrl_ff;
    logic        comm_ok_ff;
    logic        clear_ff;
    logic [31:0] tick_cnt_ff;
    logic        tick;
    logic        ack_ff;
    logic [31:0] dat_ff;
    logic        wb_req;
    logic        wb_wr;
    logic        tx_ack;
    logic        tx_nak;
    logic        rx_ack;
    logic        gate_ok;
    logic        node_ok;
    logic        qual;
    logic        any_invalid;

    // Saturating add; an all-ones operand stays all-ones
    function automatic logic [31:0] sat_add(input logic [31:0] a, input logic [31:0] b);
        logic [32:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        if (a == ldc_pkg::CNT_INVALID || sum[32]) begin
            return ldc_pkg::CNT_INVALID;
        end
        return sum[31:0];
    endfunction : sat_add

    // Register read decode
    function automatic logic [31:0] rd_word(input logic [5:0] widx);
        logic [5:0] rel;
        rd_word = 32'h0000_0000;
        rel     = widx - ldc_pkg::WIDX_RESP_BASE;
        if (widx < 6'(ldc_pkg::NUM_CNT)) begin
            rd_word = cnt_ff[widx[3:0]];
        end else if (widx == ldc_pkg::WIDX_CTRL) begin
            rd_word = ctrl_ff & ~(32'h0000_0001 << ldc_pkg::CTRL_CLEAR_BIT);
        end else if (widx == ldc_pkg::WIDX_STATUS) begin
            rd_word[ldc_pkg::STAT_COMM_OK_BIT] = comm_ok_ff;
            rd_word[ldc_pkg::STAT_INVALID_BIT] = any_invalid;
        end else if (widx >= ldc_pkg::WIDX_RESP_BASE && rel < ldc_pkg::RESP_WORDS) begin
            unique case (rel[2:0])
                ldc_pkg::SLOT_FRAMES_SENT: rd_word = cnt_ff[ldc_pkg::IDX_TX_OK];
                ldc_pkg::SLOT_NAKS:        rd_word = cnt_ff[ldc_pkg::IDX_NAK_RX];
                ldc_pkg::SLOT_EXCEPTIONS:  rd_word = cnt_ff[ldc_pkg::IDX_EXCEPTION];
                ldc_pkg::SLOT_DG_DROP:     rd_word = cnt_ff[ldc_pkg::IDX_DG_DROP];
                default:                   rd_word = 32'h0000_0000;
            endcase
        end
    endfunction : rd_word

    // Status byte decode; anything but the success code is a failure
    // Two legal codes
    assign tx_ack = tx_status_vld_i && (tx_status_byte_i == ldc_pkg::STATUS_ACK);
    assign tx_nak = tx_status_vld_i && (tx_status_byte_i != ldc_pkg::STATUS_ACK);
    assign rx_ack = rx_status_vld_i && (rx_status_byte_i == ldc_pkg::STATUS_ACK);

    assign gate_ok = !ctrl_ff[ldc_pkg::CTRL_GATE_BIT] || comm_ok_ff || tx_ack || rx_ack;
    assign node_ok = !ctrl_ff[ldc_pkg::CTRL_FILT_BIT]
                   || (peer_node_i == ctrl_ff[ldc_pkg::CTRL_NODE_LSB +: ldc_pkg::NODE_W]);
    assign qual    = gate_ok && node_ok;

    // Bus requests and write strobe
    assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wb_wr  = wb_req && wb_we_i;

    // Success seen since last clear; a success in the clear cycle survives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            comm_ok_ff <= 1'b0;
        end else if (tx_ack || rx_ack) begin
            comm_ok_ff <= 1'b1;
        end else if (clear_ff) begin
            comm_ok_ff <= 1'b0;
        end
    end

    // Control register; clear bit is a self-clearing pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff  <= ldc_pkg::CTRL_RST;
            clear_ff <= 1'b0;
        end else begin
            clear_ff <= wb_wr && wb_sel_i[0] && (wb_adr_i[7:2] == ldc_pkg::WIDX_CTRL)
                        && wb_dat_i[ldc_pkg::CTRL_CLEAR_BIT];
            if (wb_wr && (wb_adr_i[7:2] == ldc_pkg::WIDX_CTRL)) begin
                if (wb_sel_i[0]) begin
                    ctrl_ff[7:0] <= wb_dat_i[7:0] & 8'hFE;
                end
                if (wb_sel_i[1]) begin
                    ctrl_ff[15:8] <= wb_dat_i[15:8];
                end
            end
        end
    end

    // 10 ms prescaler, restarted by a clear so elapsed time lines up
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_ff || tick) begin
            tick_cnt_ff <= 32'h0000_0000;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
        end
    end
    assign tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));

    // Per-counter increment amounts
    always_comb begin
        for (int i = 0; i < ldc_pkg::NUM_CNT; i++) begin
            amt[i] = 32'h0000_0000;
        end
        amt[ldc_pkg::IDX_ELAPSED] = {31'h0000_0000, tick};
        amt[ldc_pkg::IDX_TX_OK]     = {31'h0000_0000, qual && tx_ack};
        amt[ldc_pkg::IDX_RX_OK]     = {31'h0000_0000, qual && rx_ack};
        amt[ldc_pkg::IDX_EXCEPTION] = {31'h0000_0000, qual && (early_bus_free_i || sel_timeout_i
                                        || (reset_driven_i && reset_in_tx_i))};
        amt[ldc_pkg::IDX_NAK_RX]    = {31'h0000_0000, qual && tx_nak};
        amt[ldc_pkg::IDX_ILL_PHASE] = {31'h0000_0000, qual && illegal_phase_i};
        amt[ldc_pkg::IDX_RST_DRV]   = {31'h0000_0000, gate_ok && reset_driven_i};
        amt[ldc_pkg::IDX_RST_SEEN]  = {31'h0000_0000, gate_ok && reset_seen_i
                                        && !own_reset_active_i};
        amt[ldc_pkg::IDX_CMD_ERR]   = {31'h0000_0000, qual && cmd_err_i};
        amt[ldc_pkg::IDX_RED_ERR]   = {31'h0000_0000, qual && data_err_i};
        if (qual && tx_len_vld_i) begin
            amt[ldc_pkg::IDX_BYTES_TX] = {19'h0_0000, tx_len_i};
        end
        if (qual && rx_len_vld_i) begin
            amt[ldc_pkg::IDX_BYTES_RX] = {19'h0_0000, rx_len_i};
        end
        amt[ldc_pkg::IDX_DUP_DROP]  = {31'h0000_0000, qual && dup_drop_i};
        amt[ldc_pkg::IDX_DG_DROP]   = {31'h0000_0000, qual && dg_drop_i};
    end

    // Counter bank; clear beats a same-cycle event since counts restart
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < ldc_pkg::NUM_CNT; i++) begin
            if (rst_i || clear_ff) begin
                cnt_ff[i] <= ldc_pkg::CNT_RST;
            end else begin
                cnt_ff[i] <= sat_add(cnt_ff[i], amt[i]);
            end
        end
    end

    always_comb begin
        any_invalid = 1'b0;
        for (int i = 0; i < ldc_pkg::NUM_CNT; i++) begin
            any_invalid = any_invalid || (cnt_ff[i] == ldc_pkg::CNT_INVALID);
        end
    end

    // Wishbone answer one cycle after the request; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= wb_req;
            if (wb_req && !wb_we_i) begin
                dat_ff <= rd_word(wb_adr_i[7:2]);
            end
        end
    end

    assign wb_ack_o  = ack_ff;
    assign wb_dat_o  = dat_ff;
    assign comm_ok_o = comm_ok_ff;

    // Checks on the design's own behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_clear_write;
        wb_wr && wb_sel_i[0] && (wb_adr_i[7:2] == ldc_pkg::WIDX_CTRL)
            && wb_dat_i[ldc_pkg::CTRL_CLEAR_BIT];
    endsequence

    sequence s_bank_zero;
        (cnt_ff[ldc_pkg::IDX_TX_OK] == 32'h0000_0000)
            && (cnt_ff[ldc_pkg::IDX_ELAPSED] == 32'h0000_0000)
            && (cnt_ff[ldc_pkg::IDX_BYTES_RX] == 32'h0000_0000);
    endsequence

    AST_CLEAR_ZEROES_BANK: assert property (
        s_clear_write |-> ##2 s_bank_zero)
        else $error("bank not zero two cycles after clear write");

    AST_WB_ACK_ONE_CYCLE: assert property (
        wb_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("wishbone ack not a single cycle after request");

    AST_SATURATE_HOLDS: assert property (
        (cnt_ff[ldc_pkg::IDX_BYTES_TX] == ldc_pkg::CNT_INVALID) && !clear_ff
            |=> cnt_ff[ldc_pkg::IDX_BYTES_TX] == ldc_pkg::CNT_INVALID)
        else $error("saturated counter left all-ones without a clear");

    AST_TICK_ADVANCES_TIME: assert property (
        tick && !clear_ff && (cnt_ff[ldc_pkg::IDX_ELAPSED] != ldc_pkg::CNT_INVALID)
            |=> cnt_ff[ldc_pkg::IDX_ELAPSED] == $past(cnt_ff[ldc_pkg::IDX_ELAPSED]) + 32'h1)
        else $error("elapsed counter missed a tick");

    AST_ACK_COUNTS_TX: assert property (
        qual && tx_ack && !clear_ff && (cnt_ff[ldc_pkg::IDX_TX_OK] < 32'hFFFF_FFFE)
            |=> cnt_ff[ldc_pkg::IDX_TX_OK] == $past(cnt_ff[ldc_pkg::IDX_TX_OK]) + 32'h1)
        else $error("ack status received not counted");

    AST_NAK_COUNTS: assert property (
        qual && tx_nak && !clear_ff && (cnt_ff[ldc_pkg::IDX_NAK_RX] < 32'hFFFF_FFFE)
            |=> cnt_ff[ldc_pkg::IDX_NAK_RX] == $past(cnt_ff[ldc_pkg::IDX_NAK_RX]) + 32'h1)
        else $error("negative status not counted");

    AST_TIMEOUT_RESET_BOTH: assert property (
        gate_ok && node_ok && reset_driven_i && reset_in_tx_i && !clear_ff && !any_invalid
            |=> (cnt_ff[ldc_pkg::IDX_RST_DRV] != $past(cnt_ff[ldc_pkg::IDX_RST_DRV]))
             && (cnt_ff[ldc_pkg::IDX_EXCEPTION] != $past(cnt_ff[ldc_pkg::IDX_EXCEPTION])))
        else $error("timeout reset not counted in both counters");

    AST_GATE_BLOCKS: assert property (
        ctrl_ff[ldc_pkg::CTRL_GATE_BIT] && !comm_ok_ff && !tx_status_vld_i && !rx_status_vld_i
            && !clear_ff |=> $stable(cnt_ff[ldc_pkg::IDX_DG_DROP]))
        else $error("counter moved before any successful exchange");

    AST_RESP_SPARE_ZERO: assert property (
        wb_req && !wb_we_i && (wb_adr_i[7:2] == ldc_pkg::WIDX_RESP_BASE + 6'h05)
            |=> wb_ack_o && (wb_dat_o == 32'h0000_0000))
        else $error("spare response word not zero");

endmodule : ldc_counters

// [ldc_pkg.sv]
// Constants shared by the link diagnostic counter bank
package ldc_pkg;
    // Counter bank shape
    localparam int          NUM_CNT     = 14;
    localparam int          LEN_W       = 13;
    localparam int          NODE_W      = 3;
    localparam logic [31:0] CNT_RST     = 32'h0000_0000;
    localparam logic [31:0] CNT_INVALID = 32'hFFFF_FFFF;

    // Counter indices; byte offset is four times the index
    localparam int IDX_ELAPSED   = 0;
    localparam int IDX_TX_OK     = 1;
    localparam int IDX_RX_OK     = 2;
    localparam int IDX_EXCEPTION = 3;
    localparam int IDX_NAK_RX    = 4;
    localparam int IDX_ILL_PHASE = 5;
    localparam int IDX_RST_DRV   = 6;
    localparam int IDX_RST_SEEN  = 7;
    localparam int IDX_CMD_ERR   = 8;
    localparam int IDX_RED_ERR   = 9;
    localparam int IDX_BYTES_TX  = 10;
    localparam int IDX_BYTES_RX  = 11;
    localparam int IDX_DUP_DROP  = 12;
    localparam int IDX_DG_DROP   = 13;

    // Word indices of the control, status and response window
    localparam logic [5:0] WIDX_CTRL      = 6'h10;
    localparam logic [5:0] WIDX_STATUS    = 6'h11;
    localparam logic [5:0] WIDX_RESP_BASE = 6'h20;
    localparam logic [5:0] RESP_WORDS     = 6'h08;

    // Response window slots
    localparam logic [2:0] SLOT_FRAMES_SENT = 3'h0;
    localparam logic [2:0] SLOT_NAKS        = 3'h1;
    localparam logic [2:0] SLOT_EXCEPTIONS  = 3'h2;
    localparam logic [2:0] SLOT_DG_DROP     = 3'h3;

    // Control register fields
    localparam int          CTRL_CLEAR_BIT = 0;
    localparam int          CTRL_GATE_BIT  = 1;
    localparam int          CTRL_FILT_BIT  = 2;
    localparam int          CTRL_NODE_LSB  = 8;
    localparam logic [31:0] CTRL_RST       = 32'h0000_0002;

    // Status register fields
    localparam int STAT_COMM_OK_BIT = 0;
    localparam int STAT_INVALID_BIT = 1;

    // Status byte codes on the bus
    localparam logic [7:0] STATUS_ACK = 8'h61;
    localparam logic [7:0] STATUS_NAK = 8'h1E;

    // Elapsed time tick
    localparam int TICK_MS     = 10;
    localparam int CLK_KHZ     = 125000;
    localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
endpackage : ldc_pkg

// [ldc_link_model.sv]
// Far-side datalink and port-layer event source for the counter bank
`timescale 1ns/100ps
module ldc_link_model (
    input  wire logic        clk_i,
    output logic [14:0]      strb_o,
    output logic [7:0]       stat_o,
    output logic [12:0]      len_o,
    output logic [2:0]       node_o
);
    // Quiet strobes from time zero
    initial begin
        strb_o = 15'h0000;
        stat_o = 8'h00;
        len_o  = 13'h0000;
        node_o = 3'h0;
    end

    // One event cycle, then strobes drop and data lines scramble
    // status byte, length and node values
    task automatic fire(input logic [14:0] s, input logic [7:0] b,
                        input logic [12:0] l, input logic [2:0] n);
        @(posedge clk_i);
        strb_o <= s;
        stat_o <= b;
        len_o  <= l;
        node_o <= n;
        @(posedge clk_i);
        strb_o <= 15'h0000;
        stat_o <= ~b; // Stale byte must never be reused
        len_o  <= ~l;
        node_o <= ~n;
    endtask : fire
endmodule : ldc_link_model

// [link_diag_counters_tb.sv]
// Self-checking bench for the link diagnostic counter bank
`timescale 1ns/100ps
module link_diag_counters_tb;
    localparam int TCK = 20; // Short tick keeps the run brief
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [3:0]  sel_cfg = 4'hF; // Byte lanes used by the next access
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        comm_ok_o;
    logic [14:0] strb;
    logic [7:0]  sb;
    logic [12:0] ln;
    logic [2:0]  nd;
    int          errors = 0;
    int          checks_done = 0;

    // Free-running clock
    always #4 clk_i = ~clk_i;

    ldc_link_model m (.clk_i(clk_i), .strb_o(strb), .stat_o(sb), .len_o(ln), .node_o(nd));

    ldc_counters #(.TICK_CYCLES(TCK)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .peer_node_i(nd),
        .tx_status_vld_i(strb[0]), .tx_status_byte_i(sb), .rx_status_vld_i(strb[1]),
        .rx_status_byte_i(sb), .early_bus_free_i(strb[2]), .sel_timeout_i(strb[3]),
        .reset_driven_i(strb[4]), .reset_in_tx_i(strb[5]), .own_reset_active_i(strb[6]),
        .reset_seen_i(strb[7]), .illegal_phase_i(strb[8]), .cmd_err_i(strb[9]),
        .data_err_i(strb[10]), .tx_len_vld_i(strb[11]), .tx_len_i(ln),
        .rx_len_vld_i(strb[12]), .rx_len_i(ln), .dup_drop_i(strb[13]),
        .dg_drop_i(strb[14]), .comm_ok_o(comm_ok_o));

    // Verdict and end of run
    task automatic stop_test();
        $display("Checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // One classic cycle; request held until ack is sampled high
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd_v);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= sel_cfg;
        wb_dat_i <= wd;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd_v = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 50) begin
            errors++;
            $display("FAIL ack at %h expected 1 seen timeout", a);
            stop_test();
        end
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(1'b1, a, d, dummy);
    endtask : wr

    // Read and compare one word
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        xfer(1'b0, a, 32'h0000_0000, v);
        checks_done++;
        if (v !== exp) begin
            errors++;
            $display("FAIL reg %h expected %h seen %h", a, exp, v);
        end
    endtask : rd

    // Compare the success flag output
    task automatic chk_ok(input logic exp);
        checks_done++;
        if (comm_ok_o !== exp) begin
            errors++;
            $display("FAIL comm_ok_o expected %b seen %b", exp, comm_ok_o);
        end
    endtask : chk_ok

    // Reset values, read-only counters, unmapped places
    task automatic t_reset();
        for (int i = 1; i < 16; i++) rd(8'(i * 4), 32'h0000_0000);
        rd(8'h40, ldc_pkg::CTRL_RST);
        rd(8'h44, 32'h0000_0000);
        chk_ok(1'b0);
        wr(8'h04, 32'hFFFF_FFFF);
        wr(8'hFC, 32'h1234_5678);
        rd(8'h04, 32'h0000_0000);
        rd(8'hFC, 32'h0000_0000);
    endtask : t_reset

    // Events dropped until a successful exchange
    task automatic t_gate();
        m.fire(15'h2000, 8'h00, 13'h0000, 3'h0);
        rd(8'h30, 32'h0000_0000);
        m.fire(15'h0001, ldc_pkg::STATUS_ACK, 13'h0000, 3'h0);
        rd(8'h04, 32'h0000_0001);
        rd(8'h44, 32'h0000_0001);
        chk_ok(1'b1);
        m.fire(15'h2000, 8'h00, 13'h0000, 3'h0);
        rd(8'h30, 32'h0000_0001);
    endtask : t_gate

    // Every event kind but a transmit ack, then each counter but elapsed time
    task automatic t_events();
        logic [31:0] e [1:13];
        e = '{32'h1, 32'h1, 32'h3, 32'h1, 32'h1, 32'h2, 32'h1, 32'h1, 32'h1,
              32'h1FFF, 32'h2001, 32'h2, 32'h1};
        m.fire(15'h0002, ldc_pkg::STATUS_ACK, 13'h0000, 3'h0);
        m.fire(15'h0001, ldc_pkg::STATUS_NAK, 13'h0000, 3'h0);
        m.fire(15'h0004, 8'h00, 13'h0000, 3'h0);
        m.fire(15'h0008, 8'h00, 13'h0000, 3'h0);
        m.fire(15'h0030, 8'h00, 13'h0000, 3'h0);
        m.fire(15'h0010, 8'h00, 13'h0000, 3'h0);
        m.fire(15'h00C0, 8'h00, 13'h0000, 3'h0);
        m.fire(15'h0080, 8'h00, 13'h0000, 3'h0);
        m.fire(15'h0700, 8'h00, 13'h0000, 3'h0);
        m.fire(15'h1800, 8'h00, 13'h1FFF, 3'h0);
        m.fire(15'h1000, 8'h00, 13'h0002, 3'h0);
        m.fire(15'h6000, 8'h00, 13'h0000, 3'h0);
        for (int i = 1; i < 14; i++) rd(8'(i * 4), e[i]);
    endtask : t_events

    // Response window slots and zero tail
    task automatic t_window();
        rd(8'h80, 32'h1);
        rd(8'h84, 32'h1);
        rd(8'h88, 32'h3);
        rd(8'h8C, 32'h1);
        for (int i = 4; i < 8; i++) rd(8'(8'h80 + i * 4), 32'h0);
    endtask : t_window

    // Count only events to one chosen node; byte lanes gate the control word
    task automatic t_filter();
        wr(8'h40, 32'h0000_0506);
        rd(8'h40, 32'h0000_0506);
        m.fire(15'h4000, 8'h00, 13'h0000, 3'h3);
        rd(8'h34, 32'h1);
        m.fire(15'h4000, 8'h00, 13'h0000, 3'h5);
        rd(8'h34, 32'h2);
        sel_cfg = 4'h2;
        wr(8'h40, 32'h0000_0701);
        sel_cfg = 4'hF;
        rd(8'h40, 32'h0000_0706);
        m.fire(15'h4000, 8'h00, 13'h0000, 3'h7);
        rd(8'h34, 32'h3);
    endtask : t_filter

    // Clear zeroes the bank and restarts elapsed time
    task automatic t_clear();
        wr(8'h40, 32'h0000_0003);
        repeat (TCK * 3 + 5) @(posedge clk_i);
        rd(8'h00, 32'h3);
        for (int i = 1; i < 14; i++) rd(8'(i * 4), 32'h0);
        rd(8'h44, 32'h0);
        chk_ok(1'b0);
        m.fire(15'h2000, 8'h00, 13'h0000, 3'h0);
        rd(8'h30, 32'h0);
    endtask : t_clear

    // Main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_gate();
        t_events();
        t_window();
        t_filter();
        t_clear();
        stop_test();
    end
endmodule : link_diag_counters_tb
